// ### design/ssrd_top.v
// slave request decoder: checks, offset mapping, store access and result words
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "ssrd_map.vh"
module ssrd_top (
  input wire clk_i, // clock, 10 MHz
  input wire rst_i, // async reset, high
  input wire [4:0] addr_i, // register index
  input wire [15:0] wdata_i, // register write data
  input wire wr_i, // write strobe
  input wire rd_i, // read strobe
  output reg [15:0] rdata_o, // read data, cycle after strobe
  input wire req_valid_i, // request present
  output wire req_ready_o, // request taken when high
  input wire [5:0] req_station_i, // source station number
  input wire [7:0] req_func_i, // function code
  input wire [15:0] req_addr_i, // data address
  input wire [15:0] req_size_i, // data size
  input wire wd_valid_i, // write data word present
  input wire [15:0] wd_data_i, // write data word
  output wire wd_ready_o, // write data word taken
  output reg rsp_valid_o, // read data word valid
  output reg [15:0] rsp_data_o, // read data word
  output reg rsp_last_o, // last read word
  output reg done_o // request finished, one cycle
);
  localparam S_IDLE = 2'd0;
  localparam S_CHK = 2'd1;
  localparam S_RUN = 2'd2;
  localparam S_DONE = 2'd3;
  reg [1:0] st_reg;
  reg [7:0] fc_reg;
  reg [15:0] ad_reg;
  reg [15:0] sz_reg;
  reg [5:0] sn_reg;
  reg [15:0] coil_off_reg;
  reg [15:0] rly_off_reg;
  reg [15:0] ireg_off_reg;
  reg [15:0] hold_off_reg;
  reg [15:0] win_lo_reg;
  reg [15:0] win_hi_reg;
  reg [15:0] result_reg;
  reg [2:0] res_reg;
  reg [7:0] parm_reg;
  reg [15:0] stn_word_reg;
  reg [15:0] fc_word_reg;
  reg [15:0] ad_word_reg;
  reg [15:0] sz_word_reg;
  reg [7:0] code_reg;
  reg [7:0] det_reg;
  reg fmt_reg;
  reg [16:0] cur_reg;
  reg [16:0] cnt_reg;
  reg area_reg;
  reg bit_reg;
  reg wr_reg;
  reg [20:0] lbf_reg;
  reg [20:0] lbl_reg;
  reg p1_reg;
  reg l1_reg;
  reg [`SSRD_AW-1:0] haddr_reg;
  reg [`SSRD_AW-1:0] iaddr_reg;
  wire f_ok;
  wire f_bit;
  wire f_wr;
  wire f_one;
  wire f_loop;
  wire [1:0] f_sel;
  wire [15:0] hq;
  wire [15:0] iq;
  wire [15:0] hbq;
  wire [15:0] ibq;
  wire [15:0] mask;
  wire issue;
  wire wtake;
  wire [15:0] hmask_a;
  wire [15:0] hmask_b;
  wire [15:0] imask_b;
  reg [15:0] off;
  reg [20:0] lb_f;
  reg [20:0] lb_l;
  reg [16:0] wf;
  reg [16:0] wl;
  reg size_bad;
  reg addr_bad;
  reg win_bad;

  ssrd_fdec u_fdec (
    .fc_i(fc_reg),
    .ok_o(f_ok),
    .bit_o(f_bit),
    .wr_o(f_wr),
    .one_o(f_one),
    .loop_o(f_loop),
    .sel_o(f_sel)
  );

  // holding word store, engine on port a, software on port b
  ssrd_mem u_hold (
    .clk_i(clk_i),
    .a_addr_i(cur_reg[`SSRD_AW-1:0]),
    .a_mask_i(hmask_a),
    .a_wdata_i(wd_data_i),
    .a_q_o(hq),
    .b_addr_i(haddr_reg),
    .b_mask_i(hmask_b),
    .b_wdata_i(wdata_i),
    .b_q_o(hbq)
  );

  // input word area, filled by software, only read by requests
  ssrd_mem u_inp (
    .clk_i(clk_i),
    .a_addr_i(cur_reg[`SSRD_AW-1:0]),
    .a_mask_i(16'h0000),
    .a_wdata_i(16'h0000),
    .a_q_o(iq),
    .b_addr_i(iaddr_reg),
    .b_mask_i(imask_b),
    .b_wdata_i(wdata_i),
    .b_q_o(ibq)
  );

  // request checks on the captured fields
  always @*
  begin
    // [RULE_16] offset by function
    case (f_sel)
      `SSRD_OFF_COIL: off = coil_off_reg;
      `SSRD_OFF_RLY: off = rly_off_reg;
      `SSRD_OFF_IREG: off = ireg_off_reg;
      default: off = hold_off_reg;
    endcase
    // [RULE_14] shift by offset words
    lb_f = {5'h00, ad_reg} + {1'b0, off, 4'h0};
    lb_l = lb_f + {5'h00, sz_reg} - 21'h00_0001;
    if (f_bit)
    begin
      wf = lb_f[20:4];
      wl = lb_l[20:4];
    end
    else
    begin
      wf = {1'b0, ad_reg} + {1'b0, off};
      wl = wf + {1'b0, sz_reg} - 17'h0_0001;
    end
    size_bad = (sz_reg == 16'h0000) || (f_one && sz_reg != 16'h0001) ||
               (f_bit ? (sz_reg > `SSRD_MAX_BITS) : (sz_reg > `SSRD_MAX_WORDS));
    // [RULE_24] offset or address beyond store
    addr_bad = ({1'b0, off} >= `SSRD_WORDS17) || (wl >= `SSRD_WORDS17);
    // [RULE_17] [RULE_18] [RULE_20] window in holding words
    win_bad = f_wr && ((wf < {1'b0, win_lo_reg}) || (wl > {1'b0, win_hi_reg}));
  end

  // per bit write mask of the current word for bit operations
  genvar k;
  generate
    for (k = 0; k < 16; k = k + 1)
    begin : g_mask
      localparam [3:0] KB = k;
      wire [20:0] pos = {cur_reg, KB};
      assign mask[k] = !bit_reg || (pos >= lbf_reg && pos <= lbl_reg);
    end
  endgenerate

  // engine handshakes
  assign req_ready_o = (st_reg == S_IDLE);
  assign wd_ready_o = (st_reg == S_RUN) && wr_reg;
  assign wtake = wd_ready_o && wd_valid_i;
  assign issue = (st_reg == S_RUN) && !wr_reg;
  // [RULE_10] [RULE_21] request writes land only in the holding store; software writes also reach the input area
  assign hmask_a = wtake ? mask : 16'h0000;
  assign hmask_b = (wr_i && addr_i == `SSRD_IDX_HDATA) ? 16'hffff : 16'h0000;
  assign imask_b = (wr_i && addr_i == `SSRD_IDX_IDATA) ? 16'hffff : 16'h0000;

  // request sequencer
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_reg <= S_IDLE;
      fc_reg <= 8'h00;
      ad_reg <= 16'h0000;
      sz_reg <= 16'h0000;
      sn_reg <= 6'h00;
      code_reg <= 8'h00;
      det_reg <= 8'h00;
      fmt_reg <= 1'b0;
      cur_reg <= 17'h0_0000;
      cnt_reg <= 17'h0_0000;
      area_reg <= 1'b0;
      bit_reg <= 1'b0;
      wr_reg <= 1'b0;
      lbf_reg <= 21'h00_0000;
      lbl_reg <= 21'h00_0000;
      stn_word_reg <= 16'h0000;
      fc_word_reg <= 16'h0000;
      ad_word_reg <= 16'h0000;
      sz_word_reg <= 16'h0000;
      result_reg <= 16'h0000;
      res_reg <= 3'h0;
      parm_reg <= 8'h00;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (st_reg)
        S_IDLE:
        begin
          if (req_valid_i)
          begin
            fc_reg <= req_func_i;
            ad_reg <= req_addr_i;
            sz_reg <= req_size_i;
            sn_reg <= req_station_i;
            st_reg <= S_CHK;
          end
        end
        S_CHK:
        begin
          // [RULE_03] station word from source
          stn_word_reg <= {10'h000, sn_reg};
          // [RULE_05] received code shown
          fc_word_reg <= {8'h00, fc_reg};
          // [RULE_11] requested address shown
          ad_word_reg <= ad_reg;
          // [RULE_12] size in bits or words
          sz_word_reg <= sz_reg;
          cur_reg <= wf;
          cnt_reg <= wl - wf + 17'h0_0001;
          // [RULE_09] relays and input registers read input area
          area_reg <= (f_sel == `SSRD_OFF_RLY) || (f_sel == `SSRD_OFF_IREG);
          bit_reg <= f_bit;
          wr_reg <= f_wr;
          lbf_reg <= lb_f;
          lbl_reg <= lb_l;
          st_reg <= S_DONE;
          fmt_reg <= 1'b1;
          code_reg <= `SSRD_PR_DONE;
          det_reg <= `SSRD_DET_NONE;
          // [RULE_23] undefined code result
          if (!f_ok)
          begin
            code_reg <= `SSRD_PR_FUNC;
            det_reg <= `SSRD_DET_FUNC;
          end
          else if (f_loop)
            fmt_reg <= 1'b0;
          else if (size_bad)
          begin
            code_reg <= `SSRD_PR_SIZE;
            det_reg <= `SSRD_DET_SIZE;
          end
          // [RULE_17] [RULE_24] refuse before any store access
          else if (addr_bad || win_bad)
          begin
            code_reg <= `SSRD_PR_ADDR;
            det_reg <= `SSRD_DET_ADDR;
          end
          else
          begin
            fmt_reg <= 1'b0;
            st_reg <= S_RUN;
          end
        end
        S_RUN:
        begin
          // one word per cycle, writes wait for data
          if (issue || wtake)
          begin
            cur_reg <= cur_reg + 17'h0_0001;
            cnt_reg <= cnt_reg - 17'h0_0001;
            if (cnt_reg == 17'h0_0001)
              st_reg <= S_DONE;
          end
        end
        S_DONE:
        begin
          // hold until the read pipe has drained
          if (!p1_reg && !rsp_valid_o)
          begin
            result_reg <= {code_reg, 8'h00};
            // [RULE_22] outcome code in status
            res_reg <= fmt_reg ? `SSRD_RES_FMT : `SSRD_RES_REC_OK;
            // [RULE_01] [RULE_02] detail or station
            parm_reg <= fmt_reg ? det_reg : {2'h0, sn_reg};
            done_o <= 1'b1;
            st_reg <= S_IDLE;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // read pipe: store latency, then area select into the data output
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      p1_reg <= 1'b0;
      l1_reg <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
      rsp_last_o <= 1'b0;
    end
    else
    begin
      p1_reg <= issue;
      l1_reg <= issue && (cnt_reg == 17'h0_0001);
      rsp_valid_o <= p1_reg;
      rsp_last_o <= l1_reg;
      // [RULE_09] bit ops return whole words of the bit view
      if (p1_reg)
        rsp_data_o <= area_reg ? iq : hq;
    end
  end

  // software side registers; offsets taken as unsigned
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      coil_off_reg <= 16'h0000;
      rly_off_reg <= 16'h0000;
      ireg_off_reg <= 16'h0000;
      hold_off_reg <= 16'h0000;
      win_lo_reg <= 16'h0000;
      win_hi_reg <= 16'h0000;
      haddr_reg <= 10'h000;
      iaddr_reg <= 10'h000;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `SSRD_IDX_COIL_OFF: coil_off_reg <= wdata_i;
        `SSRD_IDX_RLY_OFF: rly_off_reg <= wdata_i;
        `SSRD_IDX_IREG_OFF: ireg_off_reg <= wdata_i;
        `SSRD_IDX_HOLD_OFF: hold_off_reg <= wdata_i;
        `SSRD_IDX_WIN_LO: win_lo_reg <= wdata_i;
        `SSRD_IDX_WIN_HI: win_hi_reg <= wdata_i;
        `SSRD_IDX_HADDR: haddr_reg <= wdata_i[`SSRD_AW-1:0];
        `SSRD_IDX_IADDR: iaddr_reg <= wdata_i[`SSRD_AW-1:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      case (addr_i)
        `SSRD_IDX_RESULT: rdata_o <= result_reg;
        `SSRD_IDX_STATUS: rdata_o <= {st_reg != S_IDLE, res_reg, 4'h0, parm_reg};
        `SSRD_IDX_STATION: rdata_o <= stn_word_reg;
        // [RULE_04] option word unused
        `SSRD_IDX_OPTION: rdata_o <= 16'h0000;
        `SSRD_IDX_FUNC: rdata_o <= fc_word_reg;
        `SSRD_IDX_DADDR: rdata_o <= ad_word_reg;
        `SSRD_IDX_DSIZE: rdata_o <= sz_word_reg;
        // [RULE_13] remote cpu always zero
        `SSRD_IDX_RCPU: rdata_o <= 16'h0000;
        `SSRD_IDX_COIL_OFF: rdata_o <= coil_off_reg;
        `SSRD_IDX_RLY_OFF: rdata_o <= rly_off_reg;
        `SSRD_IDX_IREG_OFF: rdata_o <= ireg_off_reg;
        `SSRD_IDX_HOLD_OFF: rdata_o <= hold_off_reg;
        `SSRD_IDX_WIN_LO: rdata_o <= win_lo_reg;
        `SSRD_IDX_WIN_HI: rdata_o <= win_hi_reg;
        `SSRD_IDX_HADDR: rdata_o <= {6'h00, haddr_reg};
        // store data reflects the address held one cycle earlier
        `SSRD_IDX_HDATA: rdata_o <= hbq;
        `SSRD_IDX_IADDR: rdata_o <= {6'h00, iaddr_reg};
        `SSRD_IDX_IDATA: rdata_o <= ibq;
        default: rdata_o <= 16'h0000;
      endcase
    end
  end
endmodule // ssrd_top

// ### design/ssrd_map.vh
// register map, field codes and limits of the serial slave request decoder
// Behaviour
// [RULE_01] on parameter format fault, parameter field gives detail code 00 to 08
// [RULE_02] on every other outcome, parameter field gives the requesting station number
// [RULE_03] station number word shows the source station, range 0 to 63
// [RULE_04] option word carries nothing and is never used by requests
// [RULE_05] function code word shows the received function code
// [RULE_06] accept 01H-06H, 08H loopback, 0FH, 10H; 00H, 07H, 0CH unused
// [RULE_07] extended codes 09H, 0AH, 0BH, 0DH, 0EH are refused
// [RULE_08] 01H, 02H, 05H, 0FH are bit operations; 03H, 04H, 06H, 10H word operations
// [RULE_09] coils and holding registers use holding store; relays and input registers input area
// [RULE_10] as master, message data only come from the holding word store or bit view
// [RULE_11] data address word shows the requested data address
// [RULE_12] data size word shows requested size, bits for bit ops, words for word ops
// [RULE_13] remote cpu word always reads zero
// [RULE_14] local position is shifted by the selected offset in words before access
// [RULE_15] software loads only non-negative offsets
// [RULE_16] offset chosen by function: coil, input relay, input register or holding
// [RULE_17] write outside the low and high window is an error and writes nothing
// [RULE_18] window bounds are word addresses into the holding store
// [RULE_19] software keeps zero <= low <= high <= largest store address
// [RULE_20] window check applies only to 05H, 06H, 0FH and 10H
// [RULE_21] all written data goes into the holding store
// [RULE_22] status result field gives the outcome, 4 meaning parameter format fault
// [RULE_23] undefined function code gives processing result 81xxH
// [RULE_24] data address or offset out of range gives processing result 82xxH
`ifndef SSRD_MAP_VH
`define SSRD_MAP_VH
// register indices on the plain port
`define SSRD_IDX_RESULT 5'h00
`define SSRD_IDX_STATUS 5'h01
`define SSRD_IDX_STATION 5'h02
`define SSRD_IDX_OPTION 5'h03
`define SSRD_IDX_FUNC 5'h04
`define SSRD_IDX_DADDR 5'h05
`define SSRD_IDX_DSIZE 5'h06
`define SSRD_IDX_RCPU 5'h07
`define SSRD_IDX_COIL_OFF 5'h08
`define SSRD_IDX_RLY_OFF 5'h09
`define SSRD_IDX_IREG_OFF 5'h0a
`define SSRD_IDX_HOLD_OFF 5'h0b
`define SSRD_IDX_WIN_LO 5'h0c
`define SSRD_IDX_WIN_HI 5'h0d
`define SSRD_IDX_HADDR 5'h18
`define SSRD_IDX_HDATA 5'h19
`define SSRD_IDX_IADDR 5'h1a
`define SSRD_IDX_IDATA 5'h1b
// status word: [15] request busy, [14:12] result, [7:0] parameter
`define SSRD_ST_BUSY 15
`define SSRD_RES_REC_OK 3'h2
`define SSRD_RES_FMT 3'h4
// processing result codes, upper byte
`define SSRD_PR_DONE 8'h10
`define SSRD_PR_FUNC 8'h81
`define SSRD_PR_ADDR 8'h82
`define SSRD_PR_SIZE 8'h83
// parameter format fault details
`define SSRD_DET_NONE 8'h00
`define SSRD_DET_ADDR 8'h06
`define SSRD_DET_SIZE 8'h07
`define SSRD_DET_FUNC 8'h08
// offset selectors
`define SSRD_OFF_COIL 2'h0
`define SSRD_OFF_RLY 2'h1
`define SSRD_OFF_IREG 2'h2
`define SSRD_OFF_HOLD 2'h3
// store geometry and size limits
`define SSRD_AW 10
`define SSRD_WORDS 1024
`define SSRD_WORDS17 17'h0_0400
`define SSRD_MAX_BITS 16'h07d0
`define SSRD_MAX_WORDS 16'h007d
`endif

// ### design/ssrd_mem.v
// dual port word store with per bit write mask and registered read data
`timescale 1ns/1ps
`include "ssrd_map.vh"
module ssrd_mem (
  input wire clk_i, // clock
  input wire [`SSRD_AW-1:0] a_addr_i, // port a address
  input wire [15:0] a_mask_i, // port a bit write mask
  input wire [15:0] a_wdata_i, // port a write data
  output reg [15:0] a_q_o, // port a read data
  input wire [`SSRD_AW-1:0] b_addr_i, // port b address
  input wire [15:0] b_mask_i, // port b bit write mask
  input wire [15:0] b_wdata_i, // port b write data
  output reg [15:0] b_q_o // port b read data
);
  reg [15:0] mem [0:`SSRD_WORDS-1];
  // merged words of each port, port a on top of port b
  wire [15:0] wb = (mem[b_addr_i] & ~b_mask_i) | (b_wdata_i & b_mask_i);
  wire [15:0] wa = (a_addr_i == b_addr_i && b_mask_i != 16'h0000) ? wb : mem[a_addr_i];
  // port a applied last so it wins on a shared word
  always @(posedge clk_i)
  begin
    if (b_mask_i != 16'h0000)
      mem[b_addr_i] <= wb;
    if (a_mask_i != 16'h0000)
      mem[a_addr_i] <= (wa & ~a_mask_i) | (a_wdata_i & a_mask_i);
    // read before write on both ports
    a_q_o <= mem[a_addr_i];
    b_q_o <= mem[b_addr_i];
  end
endmodule // ssrd_mem

// ### design/ssrd_fdec.v
// function code classifier: legality, data type, direction and offset choice
`timescale 1ns/1ps
`include "ssrd_map.vh"
module ssrd_fdec (
  input wire [7:0] fc_i, // received function code
  output reg ok_o, // code is accepted
  output reg bit_o, // bit data operation
  output reg wr_o, // write operation
  output reg one_o, // single item write
  output reg loop_o, // loopback test
  output reg [1:0] sel_o // offset selector
);
  // extended and unused codes fall to the default, which refuses them
  always @*
  begin
    ok_o = 1'b1;
    bit_o = 1'b0;
    wr_o = 1'b0;
    one_o = 1'b0;
    loop_o = 1'b0;
    sel_o = `SSRD_OFF_HOLD;
    case (fc_i)
      // [RULE_08] [RULE_16] bit codes, coil or input relay offset
      8'h01: begin bit_o = 1'b1; sel_o = `SSRD_OFF_COIL; end
      8'h02: begin bit_o = 1'b1; sel_o = `SSRD_OFF_RLY; end
      8'h03: sel_o = `SSRD_OFF_HOLD;
      8'h04: sel_o = `SSRD_OFF_IREG;
      8'h05: begin bit_o = 1'b1; wr_o = 1'b1; one_o = 1'b1; sel_o = `SSRD_OFF_COIL; end
      8'h06: begin wr_o = 1'b1; one_o = 1'b1; end
      // [RULE_06] loopback accepted
      8'h08: loop_o = 1'b1;
      8'h0f: begin bit_o = 1'b1; wr_o = 1'b1; sel_o = `SSRD_OFF_COIL; end
      8'h10: wr_o = 1'b1;
      // [RULE_07] extended codes refused
      default: ok_o = 1'b0;
    endcase
  end
endmodule // ssrd_fdec

// ### testbench/ssrd_chk.sv
// port checker of the slave request decoder
`timescale 1ns/1ps
`include "ssrd_map.vh"
module ssrd_chk (
  input wire clk_i, // clock
  input wire rst_i, // async reset, high
  input wire [4:0] addr_i, // register index
  input wire rd_i, // read strobe
  input wire [15:0] rdata_o, // read data
  input wire req_valid_i, // request present
  input wire req_ready_o, // decoder idle
  input wire wd_ready_o, // write word taken
  input wire rsp_valid_o, // read word valid
  input wire rsp_last_o, // last read word
  input wire done_o // finish pulse
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request taken, and reads of the words that never carry data
  sequence s_take;
    req_valid_i && req_ready_o;
  endsequence
  sequence s_cpu_rd;
    rd_i && addr_i == `SSRD_IDX_RCPU;
  endsequence
  sequence s_opt_rd;
    rd_i && addr_i == `SSRD_IDX_OPTION;
  endsequence
  // a taken request must close, even a refused one needs three cycles
  fin_bound_a: assert property (s_take |-> ##[3:1000] done_o)
    else $error("request never finished");
  fin_pulse_a: assert property (done_o |=> !done_o)
    else $error("finish pulse too long");
  idle_after_a: assert property (done_o |-> req_ready_o)
    else $error("not idle at finish");
  take_busy_a: assert property (s_take |=> !req_ready_o)
    else $error("second request accepted");
  cpu_zero_a: assert property (s_cpu_rd |=> rdata_o == 16'h0000)
    else $error("remote cpu word not zero");
  option_zero_a: assert property (s_opt_rd |=> rdata_o == 16'h0000)
    else $error("option word not zero");
  // store writes only inside a request
  wd_busy_a: assert property (wd_ready_o |-> !req_ready_o)
    else $error("write word taken while idle");
  rsp_busy_a: assert property (rsp_valid_o |-> !req_ready_o)
    else $error("read word while idle");
  last_valid_a: assert property (rsp_last_o |-> rsp_valid_o)
    else $error("last flag without word");
  last_done_a: assert property (rsp_last_o |-> ##2 done_o)
    else $error("last word not followed by finish");
  rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without strobe");
endmodule // ssrd_chk
bind ssrd_top ssrd_chk i_ssrd_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .wd_ready_o(wd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_last_o(rsp_last_o),
  .done_o(done_o));

// ### testbench/ssrd_master_model.sv
// remote master station model: requests, write words, read word capture
`timescale 1ns/1ps
module ssrd_master_model (
  input wire clk_i, // clock
  input wire req_ready_i, // decoder idle
  input wire wd_ready_i, // write word taken
  input wire rsp_valid_i, // read word valid
  input wire [15:0] rsp_data_i, // read word
  output reg req_valid_o = 1'b0, // request present
  output reg [5:0] req_station_o = 6'h00, // source station
  output reg [7:0] req_func_o = 8'h00, // function code
  output reg [15:0] req_addr_o = 16'h0000, // data address
  output reg [15:0] req_size_o = 16'h0000, // data size
  output reg wd_valid_o = 1'b0, // write word present
  output reg [15:0] wd_data_o = 16'h0000 // write word
);
  logic [15:0] wq[$]; // words still to send
  logic [15:0] rq[$]; // words received
  bit slow = 1'b0; // stall every other cycle
  bit gap = 1'b0;
  bit hold;
  // request held until taken, fields scrambled once released
  // six bit station
  task automatic send(input logic [5:0] st, input logic [7:0] fc,
    input logic [15:0] ad, input logic [15:0] sz);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    {req_station_o, req_func_o, req_addr_o, req_size_o} <= {st, fc, ad, sz};
    @(negedge clk_i);
    while (!req_ready_i)
      @(negedge clk_i);
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    {req_station_o, req_func_o, req_addr_o, req_size_o} <= ~{st, fc, ad, sz};
  endtask
  // a word not yet taken is held; an idle data line toggles
  always @(posedge clk_i)
  begin
    hold = wd_valid_o && !wd_ready_i;
    if (wd_valid_o && wd_ready_i)
      void'(wq.pop_front());
    gap <= !gap;
    if (!hold)
    begin
      wd_valid_o <= wq.size() != 0 && !(slow && gap);
      wd_data_o <= (wq.size() != 0 && !(slow && gap)) ? wq[0] : ~wd_data_o;
    end
    if (rsp_valid_i)
      rq.push_back(rsp_data_i);
  end
endmodule // ssrd_master_model

// ### testbench/ssrd_top_tb.sv
// bench of the request decoder with reference model and remote master
`timescale 1ns/1ps
`include "ssrd_map.vh"
module ssrd_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] addr_i = 5'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire [15:0] rdata_o, req_addr_i, req_size_i, wd_data_i, rsp_data_o;
  wire [7:0] req_func_i;
  wire [5:0] req_station_i;
  wire req_valid_i, req_ready_o, wd_valid_i, wd_ready_o, rsp_valid_o, done_o;
  int error_cnt = 0;
  int check_count = 0;
  logic [15:0] hm [0:1023]; // holding store mirror
  logic [15:0] im [0:127]; // input area mirror
  int off[4];
  int lo;
  int hi;
  int wt[12][3] = '{'{6,19,1}, '{6,20,1}, '{6,30,1}, '{6,31,1}, '{16,28,3}, '{16,28,4},
    '{15,320,16}, '{15,316,8}, '{5,495,1}, '{5,496,1}, '{3,17,16}, '{1,300,64}};
  int et[8][3] = '{'{3,0,125}, '{1,0,2000}, '{1,0,2001}, '{3,0,126}, '{5,0,2}, '{16,0,0},
    '{3,1000,30}, '{9,0,0}};
  int ft[8] = '{1, 2, 3, 4, 5, 6, 15, 16};
  ssrd_top i_ssrd_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_station_i(req_station_i), .req_func_i(req_func_i),
    .req_addr_i(req_addr_i), .req_size_i(req_size_i), .wd_valid_i(wd_valid_i),
    .wd_data_i(wd_data_i), .wd_ready_o(wd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_last_o(), .done_o(done_o));
  ssrd_master_model i_ssrd_master_model (.clk_i(clk_i), .req_ready_i(req_ready_o),
    .wd_ready_i(wd_ready_o), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
    .req_valid_o(req_valid_i), .req_station_o(req_station_i), .req_func_o(req_func_i),
    .req_addr_o(req_addr_i), .req_size_o(req_size_i), .wd_valid_o(wd_valid_i),
    .wd_data_o(wd_data_i));
  // 100 ns period
  always #50 clk_i = ~clk_i;
  // compare and count; x matches only x
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  // single cycle bus write
  task automatic bwr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // bus read, data looked at only in the following cycle
  task automatic brd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, exp);
  endtask
  task automatic cfg(input int c, r, i, h, l, u);
    off = '{c, r, i, h};
    lo = l;
    hi = u;
    for (int k = 0; k < 6; k++)
      bwr(5'(8 + k), 16'(k < 4 ? off[k] : k == 4 ? l : u));
  endtask
  // one request through the partner, every result word except option and remote cpu compared
  task automatic req(input int fc, ad, sz);
    int st, o, fb, fw, lw, code, n;
    bit bo, wr;
    logic [15:0] d;
    logic [15:0] eq[$];
    st = $urandom % 64;
    bo = fc inside {1, 2, 5, 15};
    wr = fc inside {5, 6, 15, 16};
    o = off[fc inside {1, 5, 15} ? 0 : fc == 2 ? 1 : fc == 4 ? 2 : 3];
    fb = ad + o * 16;
    fw = bo ? fb / 16 : ad + o;
    lw = bo ? (fb + sz - 1) / 16 : fw + sz - 1;
    if (!(fc inside {1, 2, 3, 4, 5, 6, 8, 15, 16}))
      code = 16'h8108;
    else if (fc == 8)
      code = 16'h1000;
    else if (sz == 0 || sz > (bo ? 2000 : 125) || (fc inside {5, 6} && sz != 1))
      code = 16'h8307;
    else if (o >= 1024 || lw >= 1024 || (wr && (fw < lo || lw > hi)))
      code = 16'h8206;
    else
      code = 16'h1000;
    if (code == 16'h1000 && fc != 8)
      for (int w = fw; w <= lw; w++)
      begin
        d = 16'($urandom);
        if (wr)
          i_ssrd_master_model.wq.push_back(d);
        for (int b = 0; b < 16; b++)
          if (wr && (!bo || (w * 16 + b >= fb && w * 16 + b < fb + sz)))
            hm[w][b] = d[b];
        if (!wr)
          eq.push_back(fc inside {2, 4} ? im[w] : hm[w]);
      end
    i_ssrd_master_model.rq.delete();
    i_ssrd_master_model.send(6'(st), 8'(fc), 16'(ad), 16'(sz));
    n = 0;
    while (done_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk({15'h0000, done_o}, 16'h0001);
    chk(16'(i_ssrd_master_model.wq.size()), 16'h0000);
    i_ssrd_master_model.wq.delete();
    brd(`SSRD_IDX_RESULT, {code[15:8], 8'h00});
    brd(`SSRD_IDX_STATUS, {1'b0, (code[15] ? `SSRD_RES_FMT : `SSRD_RES_REC_OK), 4'h0,
      (code[15] ? code[7:0] : {2'b00, 6'(st)})});
    brd(`SSRD_IDX_STATION, {10'h000, 6'(st)});
    brd(`SSRD_IDX_FUNC, {8'h00, 8'(fc)});
    brd(`SSRD_IDX_DADDR, 16'(ad));
    brd(`SSRD_IDX_DSIZE, 16'(sz));
    chk(16'(i_ssrd_master_model.rq.size()), 16'(eq.size()));
    foreach (eq[k])
      chk(i_ssrd_master_model.rq[k], eq[k]);
  endtask
  // counts, verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial
  begin
    int f;
    void'($urandom(32'h9f98));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 8; r < 14; r++)
      brd(5'(r), 16'h0000);
    brd(`SSRD_IDX_OPTION, 16'h0000);
    bwr(`SSRD_IDX_RCPU, 16'h00a5);
    brd(`SSRD_IDX_RCPU, 16'h0000);
    brd(5'h10, 16'h0000);
    // preload stores; words above 127 stay unknown
    for (int w = 0; w < 128; w++)
    begin
      hm[w] = 16'($urandom);
      im[w] = 16'($urandom);
      bwr(`SSRD_IDX_HADDR, 16'(w));
      bwr(`SSRD_IDX_HDATA, hm[w]);
      bwr(`SSRD_IDX_IADDR, 16'(w));
      bwr(`SSRD_IDX_IDATA, im[w]);
    end
    brd(`SSRD_IDX_HDATA, hm[127]);
    brd(`SSRD_IDX_IDATA, im[127]);
    $display("test registers done");
    cfg(0, 0, 0, 0, 0, 1023);
    for (f = 0; f < 18; f++)
      req(f, $urandom % 64, 1);
    $display("test function codes done");
    cfg(5, 3, 7, 9, 0, 1023);
    for (int k = 0; k < 24; k++)
    begin
      f = ft[$urandom % 8];
      req(f, $urandom % 40, f inside {5, 6} ? 1 : (f < 3 || f == 15) ? 1 + $urandom % 100
        : 1 + $urandom % 8);
    end
    $display("test offsets done");
    cfg(0, 0, 0, 0, 20, 30);
    foreach (wt[k])
      req(wt[k][0], wt[k][1], wt[k][2]);
    $display("test write window done");
    cfg(0, 0, 0, 0, 0, 1023);
    foreach (et[k])
      req(et[k][0], et[k][1], et[k][2]);
    cfg(0, 0, 0, 1024, 0, 1023);
    req(3, 0, 1);
    req(3, 0, 0);
    $display("test limits done");
    cfg(2, 0, 0, 4, 0, 1023);
    i_ssrd_master_model.slow = 1'b1;
    req(16, 40, 8);
    req(15, 700, 40);
    req(3, 40, 8);
    $display("test slow partner done");
    finish_test;
  end
  // hang guard, far beyond the expected run
  initial
  begin
    #(20000 * 100);
    error_cnt++;
    finish_test;
  end
endmodule // ssrd_top_tb
